// [core/mts_pkg.sv]
// Shared constants for the multiplier transfer stall control.
// Assumes one core clock; no software-visible registers.
package mts_pkg;
    // Instruction class presented with the operation-stage valid
    localparam logic [1:0] KIND_OTHER = 2'h0;
    localparam logic [1:0] KIND_STS_REG = 2'h1;
    localparam logic [1:0] KIND_STS_MEM = 2'h2;
    localparam logic [1:0] KIND_LDS_REG = 2'h3;
    // Multiplier busy cycles after a word multiply-accumulate's final access
    localparam int MM_WORD_CYCLES = 2;
    localparam int MAC_WIDTH = 32;
endpackage

// [core/mts_busy_if.sv]
// Link between the stall controller and its multiplier busy counter.
// Assumes both ends run on the core clock.
`timescale 1ns/100ps
`default_nettype none
interface mts_busy_if;
    logic start;
    logic busy;
    modport ctrl (output start, input busy);
    modport cnt (input start, output busy);
endinterface
`default_nettype wire

// [core/mts_busy_cnt.sv]
// Multiplier busy tracker: counts the multiplier's compute cycles.
// Assumes start pulses at the end of the issuing instruction's last access.
`timescale 1ns/100ps
`default_nettype none
module mts_busy_cnt #(
    parameter int CYCLES = mts_pkg::MM_WORD_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Controller side
    mts_busy_if.cnt bus
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;

    // Runs on past slot boundaries; only the count decides the end
    assign cnt_nxt = bus.start ? LOAD : (cnt_r != '0 ? cnt_r - 1'b1 : cnt_r);
    assign bus.busy = (cnt_r != '0);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else if (clk_en) begin
            cnt_r <= cnt_nxt;
        end
    end

    a_busy_load: assert property (
        @(posedge core_clk) disable iff (!rst_n) clk_en && bus.start |=> cnt_r == LOAD)
        else $error("busy count not loaded on start");
endmodule
`default_nettype wire

// [core/mts_stall_ctrl.sv]
// Stall control for multiply-accumulate register transfers that follow
// a word multiply-accumulate. Assumes decode presents one transfer at a
// time and holds the pipeline while stall is high.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Register-destination store gets an extra access stage that reads the multiplier.
// - That stage waits while the multiplier is busy; the access itself is one slot.
// - That stage competes with instruction fetch for the bus.
// - Store to memory gains an access stage reading multiplier and writing memory.
// - Register-source load gets an extra access stage reaching the multiplier.
// - Load access stage extends until the multiplier finishes; one slot.
// - Load access stage competes with fetch for the bus.
// - Access and fetch collisions split the slot; accesses go one after another.
// - Multiplier busy runs on after the last access, regardless of slots.
module mts_stall_ctrl #(
    parameter int MULTIPLY_ACCUMULATE_WORD_INSTR = mts_pkg::MAC_WIDTH,
    parameter int MM_CYCLES = mts_pkg::MM_WORD_CYCLES
) (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Operation stage
    input wire logic ex_valid,
    input wire logic [1:0] ex_kind,
    input wire logic mac_ma_last,
    // Data sources
    input wire logic [MULTIPLY_ACCUMULATE_WORD_INSTR-1:0] mac_value,
    input wire logic [MULTIPLY_ACCUMULATE_WORD_INSTR-1:0] gpr_rdata,
    // Fetch arbitration
    input wire logic fetch_req,
    output logic fetch_grant_r,
    // Pipeline and multiplier
    output logic stall_r,
    output logic mul_busy_r,
    output logic mul_acc_r,
    output logic mac_load_r,
    output logic [MULTIPLY_ACCUMULATE_WORD_INSTR-1:0] mac_ld_data_r,
    // Memory write
    output logic mem_wr_r,
    output logic [MULTIPLY_ACCUMULATE_WORD_INSTR-1:0] mem_wdata_r,
    // Register write-back
    output logic gpr_we_r,
    output logic [MULTIPLY_ACCUMULATE_WORD_INSTR-1:0] gpr_wdata_r
);
    typedef enum logic [1:0] {ST_IDLE, ST_MA, ST_WB} mts_state_type;

    mts_state_type state_r;
    mts_state_type state_nxt;
    logic [1:0] kind_r;
    logic [MULTIPLY_ACCUMULATE_WORD_INSTR-1:0] hold_r;

    mts_busy_if bus ();

    mts_busy_cnt #(.CYCLES(MM_CYCLES)) u_busy (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .bus(bus)
    );

    assign bus.start = mac_ma_last;

    wire is_xfer = ex_valid && (ex_kind != mts_pkg::KIND_OTHER);
    wire take = (state_r == ST_IDLE) && is_xfer;
    wire in_ma = (state_r == ST_MA);
    // Access fires only once the multiplier is idle
    wire acc_go = in_ma && !bus.busy;
    wire is_sts_reg = (kind_r == mts_pkg::KIND_STS_REG);
    wire is_sts_mem = (kind_r == mts_pkg::KIND_STS_MEM);
    wire is_lds_reg = (kind_r == mts_pkg::KIND_LDS_REG);

    // Access takes the bus first; fetch goes in the next cycle
    wire fetch_grant_nxt = fetch_req && !acc_go;
    wire stall_nxt = in_ma || (state_r == ST_WB) || take;
    wire mul_acc_nxt = acc_go;
    wire mem_wr_nxt = acc_go && is_sts_mem;
    wire mac_load_nxt = acc_go && is_lds_reg;
    wire gpr_we_nxt = (state_r == ST_WB);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (is_xfer) begin
                    state_nxt = ST_MA;
                end
            end
            ST_MA: begin
                if (acc_go) begin
                    state_nxt = is_sts_reg ? ST_WB : ST_IDLE;
                end
            end
            ST_WB: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            kind_r <= mts_pkg::KIND_OTHER;
            hold_r <= '0;
        end else if (clk_en) begin
            state_r <= state_nxt;
            if (take) begin
                kind_r <= ex_kind;
            end
            if (acc_go) begin
                hold_r <= mac_value;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fetch_grant_r <= 1'b0;
            stall_r <= 1'b0;
            mul_busy_r <= 1'b0;
            mul_acc_r <= 1'b0;
            mac_load_r <= 1'b0;
            mem_wr_r <= 1'b0;
            gpr_we_r <= 1'b0;
        end else if (clk_en) begin
            fetch_grant_r <= fetch_grant_nxt;
            stall_r <= stall_nxt;
            mul_busy_r <= bus.busy;
            mul_acc_r <= mul_acc_nxt;
            mac_load_r <= mac_load_nxt;
            mem_wr_r <= mem_wr_nxt;
            gpr_we_r <= gpr_we_nxt;
        end
    end

    // Data registers need no reset; their strobes qualify them
    always_ff @(posedge core_clk) begin
        if (clk_en) begin
            if (mac_load_nxt) begin
                mac_ld_data_r <= gpr_rdata;
            end
            if (mem_wr_nxt) begin
                mem_wdata_r <= mac_value;
            end
            if (gpr_we_nxt) begin
                gpr_wdata_r <= hold_r;
            end
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_sts_reg_access: assert property (
        clk_en && acc_go && is_sts_reg |=> mul_acc_r && !mem_wr_r && !mac_load_r)
        else $error("register store missed its multiplier access");
    a_store_held_busy: assert property (
        clk_en && in_ma && bus.busy |=> stall_r && !mul_acc_r)
        else $error("access taken while multiplier busy");
    a_fetch_yields: assert property (
        clk_en && acc_go && fetch_req |=> !fetch_grant_r)
        else $error("fetch granted during multiplier access");
    a_mem_write: assert property (
        clk_en && acc_go && is_sts_mem |=> mem_wr_r && mul_acc_r
            && mem_wdata_r == $past(mac_value))
        else $error("memory store did not write multiplier value");
    a_lds_load: assert property (
        clk_en && acc_go && is_lds_reg |=> mac_load_r && mac_ld_data_r == $past(gpr_rdata))
        else $error("register load did not reach multiplier");
    a_load_extends: assert property (
        clk_en && in_ma && bus.busy |=> state_r == ST_MA)
        else $error("access stage left while multiplier busy");
    a_fetch_after: assert property (
        clk_en && fetch_req && !acc_go |=> fetch_grant_r)
        else $error("fetch not granted on a free bus");
    a_busy_out: assert property (
        clk_en && mac_ma_last |=> ##1 mul_busy_r || !$past(clk_en))
        else $error("multiplier busy not shown after last access");
    a_writeback: assert property (
        clk_en && acc_go && is_sts_reg ##1 clk_en |=> gpr_we_r
            && gpr_wdata_r == $past(mac_value, 2))
        else $error("register store write-back missing");

    // Pulse shape and strobe ownership
    a_take_stall: assert property (
        clk_en && take |=> stall_r && in_ma)
        else $error("transfer taken without entering the access stage");
    a_idle_no_stall: assert property (
        clk_en && state_r == ST_IDLE && !is_xfer |=> !stall_r)
        else $error("pipeline held with no transfer");
    a_acc_stall: assert property (
        mul_acc_r |-> stall_r)
        else $error("pipeline released before its multiplier access");
    a_kind_held: assert property (
        clk_en && state_r != ST_IDLE |=> $stable(kind_r))
        else $error("transfer replaced while one is in progress");
    a_acc_one_slot: assert property (
        clk_en && acc_go |=> !in_ma)
        else $error("access stage outlived its multiplier access");
    a_acc_pulse: assert property (
        clk_en && mul_acc_r |=> !mul_acc_r)
        else $error("multiplier access longer than one cycle");
    a_acc_no_grant: assert property (
        mul_acc_r |-> !fetch_grant_r)
        else $error("fetch shared a cycle with the multiplier access");
    a_mem_owner: assert property (
        mem_wr_r |-> is_sts_mem)
        else $error("memory write from a non-memory transfer");
    a_load_owner: assert property (
        mac_load_r |-> is_lds_reg)
        else $error("multiplier load from a non-load transfer");
    a_busy_start: assert property (
        clk_en && mac_ma_last |=> bus.busy)
        else $error("multiplier busy not started by last access");
    a_busy_mirror: assert property (
        clk_en |=> mul_busy_r == $past(bus.busy))
        else $error("busy output does not follow the busy count");
    a_wb_follows: assert property (
        clk_en && state_r == ST_WB |=> state_r == ST_IDLE && gpr_we_r)
        else $error("write-back stage did not write the register");
    a_wb_owner: assert property (
        gpr_we_r |-> is_sts_reg)
        else $error("register write from a non-register transfer");
    a_wb_pulse: assert property (
        clk_en && gpr_we_r |=> !gpr_we_r)
        else $error("register write longer than one cycle");
endmodule
`default_nettype wire

// [sim/mts_fetch_model.sv]
// Fetch side of the shared bus: raises fetch requests, counts grants.
// Assumes a grant answers the request of the previous cycle.
`timescale 1ns/100ps
`default_nettype none
module mts_fetch_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Bench control and bus
    input wire logic want,
    input wire logic fetch_grant_r,
    output logic fetch_req,
    output int grants
);
    initial fetch_req = 1'b0;
    initial grants = 0;
    // Request is held through a split slot, never dropped by the model
    // Taken on the rising edge so falling-edge bench writes never race it
    always @(posedge core_clk) begin
        fetch_req <= rst_n & want;
    end
    always @(posedge core_clk) begin
        if (fetch_grant_r === 1'b1) grants <= grants + 1;
    end
endmodule
`default_nettype wire

// [sim/multiplier_transfer_stall_control_tb.sv]
// Self-checking bench for the multiplier transfer stall control.
// Assumes the fetch model of mts_fetch_model.sv on the shared bus.
`timescale 1ns/100ps
`default_nettype none
module multiplier_transfer_stall_control_tb;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ex_valid = 1'b0;
    logic mac_ma_last = 1'b0;
    logic clk_en = 1'b1;
    logic want = 1'b0;
    logic [1:0] ex_kind = 2'h0;
    logic [31:0] mac_value = 32'h0;
    logic [31:0] gpr_rdata = 32'h0;
    logic [31:0] st = 32'h057CC4FA;
    wire logic fetch_req, fetch_grant_r, stall_r, mul_busy_r, mul_acc_r;
    wire logic mac_load_r, mem_wr_r, gpr_we_r;
    wire logic [31:0] mac_ld_data_r, mem_wdata_r, gpr_wdata_r;
    int fail_count = 0;
    int n_tests = 0;
    int li, lb, lf;
    int grants;
    always #2 core_clk = ~core_clk;
    mts_stall_ctrl mts_stall_ctrl_i (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
        .ex_valid(ex_valid), .ex_kind(ex_kind), .mac_ma_last(mac_ma_last),
        .mac_value(mac_value), .gpr_rdata(gpr_rdata), .fetch_req(fetch_req),
        .fetch_grant_r(fetch_grant_r), .stall_r(stall_r), .mul_busy_r(mul_busy_r),
        .mul_acc_r(mul_acc_r), .mac_load_r(mac_load_r), .mac_ld_data_r(mac_ld_data_r),
        .mem_wr_r(mem_wr_r), .mem_wdata_r(mem_wdata_r), .gpr_we_r(gpr_we_r),
        .gpr_wdata_r(gpr_wdata_r));
    mts_fetch_model mts_fetch_model_i (.core_clk(core_clk), .rst_n(rst_n), .want(want),
        .fetch_grant_r(fetch_grant_r), .fetch_req(fetch_req), .grants(grants));
    function logic [31:0] rnd();
        st = st ^ (st << 13);
        st = st ^ (st >> 17);
        st = st ^ (st << 5);
        return st;
    endfunction
    function logic str(input logic [1:0] k);
        return (k == 2'h1) ? gpr_we_r : (k == 2'h2) ? mem_wr_r : mac_load_r;
    endfunction
    function logic [31:0] dat(input logic [1:0] k);
        return (k == 2'h1) ? gpr_wdata_r : (k == 2'h2) ? mem_wdata_r : mac_ld_data_r;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic run(input logic [1:0] k, input logic b, input logic fz, output int lat);
        logic [31:0] r, d;
        logic s, g0, g1, sok, mb;
        sok = 1'b1;
        mb = 1'b0;
        s = 1'b0;
        r = rnd();
        // Random fetch traffic between transfers
        repeat (r[1:0] + 1) begin
            @(negedge core_clk);
            want = r[2];
            r = rnd();
        end
        @(negedge core_clk);
        want = 1'b1;
        mac_value = rnd();
        gpr_rdata = rnd();
        @(negedge core_clk);
        // Final multiplier access coincides with the transfer's operation stage
        mac_ma_last = b;
        ex_valid = 1'b1;
        ex_kind = k;
        @(negedge core_clk);
        mac_ma_last = 1'b0;
        ex_valid = 1'b0;
        lat = 0;
        while (mul_acc_r !== 1'b1 && lat < 20) begin
            if (stall_r !== 1'b1) sok = 1'b0;
            if (mul_busy_r === 1'b1) mb = 1'b1;
            // Fresh operands each wait cycle: only the access edge may take them
            mac_value = rnd();
            gpr_rdata = rnd();
            clk_en = !(fz && lat < 3);
            @(negedge core_clk);
            lat++;
        end
        if (lat >= 20) begin
            fail_count++;
            tally_and_finish();
        end
        g0 = fetch_grant_r;
        for (int n = 0; n < 5; n++) begin
            if (s == 1'b0 && str(k) === 1'b1) begin
                s = 1'b1;
                d = dat(k);
            end
            if (mul_busy_r === 1'b1) mb = 1'b1;
            if (n == 1) g1 = fetch_grant_r;
            @(negedge core_clk);
        end
        check(s, 1'b1);
        check(d, (k == 2'h3) ? gpr_rdata : mac_value);
        check(g0, 1'b0);
        check(g1, 1'b1);
        check(sok, 1'b1);
        check(mb, b);
        for (int n = 0; n < 9 && stall_r !== 1'b0; n++) begin
            @(negedge core_clk);
            if (n == 8) begin
                fail_count++;
                tally_and_finish();
            end
        end
        $display("test kind %0d busy %0d latency %0d", k, b, lat);
    endtask
    initial begin
        repeat (16) @(negedge core_clk);
        rst_n = 1'b1;
        @(negedge core_clk);
        for (int k = 1; k < 4; k++) begin
            repeat (2) begin
                run(2'(k), 1'b0, 1'b0, li);
                run(2'(k), 1'b1, 1'b0, lb);
                check(lb, li + mts_pkg::MM_WORD_CYCLES);
                // Three frozen cycles while the multiplier is busy
                run(2'(k), 1'b1, 1'b1, lf);
                check(lf, lb + 3);
            end
        end
        ex_kind = mts_pkg::KIND_OTHER;
        ex_valid = 1'b1;
        @(negedge core_clk);
        ex_valid = 1'b0;
        repeat (3) begin
            check(stall_r, 1'b0);
            check(mul_acc_r, 1'b0);
            @(negedge core_clk);
        end
        check(grants != 0, 1'b1);
        $display("test other kind done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
